// ===== src/uir_pkg.sv
/*
  package for the usb interrupt-enable, address and endpoint-index register slice.
  assumes an 8-bit special function register bus with byte addresses.
*/
package uir_pkg;
  localparam int          UIR_NUM_EP         = 7;
  localparam logic [7:0]  UIR_OFS_IRQ_EN     = 8'hBE;
  localparam logic [7:0]  UIR_OFS_DEV_ADDR   = 8'hC6;
  localparam logic [7:0]  UIR_OFS_EP_INDEX   = 8'hC7;
  localparam logic [7:0]  UIR_OFS_EP_CONFIG  = 8'hD4;
  localparam logic [7:0]  UIR_RST_IRQ_EN     = 8'h10;
  localparam logic [7:0]  UIR_RST_EP_INDEX   = 8'h00;
  localparam logic [7:0]  UIR_MASK_IRQ_EN    = 8'h39;
  localparam logic [7:0]  UIR_MASK_EP_INDEX  = 8'h0F;
  localparam int          UIR_BIT_WAKE_EN    = 5;
  localparam int          UIR_BIT_EOR_EN     = 4;
  localparam int          UIR_BIT_SOF_EN     = 3;
  localparam int          UIR_BIT_SUSP_EN    = 0;
  localparam int          UIR_BIT_FUNC_EN    = 7;
  localparam int          UIR_BIT_EP_EN      = 7;
  localparam int          UIR_BIT_NAK_IEN    = 6;
  localparam int          UIR_BIT_NAK_OUT    = 5;
  localparam int          UIR_BIT_NAK_IN     = 4;
endpackage

// ===== src/uir_ep_slot.sv
/*
  one endpoint's enable, nak interrupt enable and nak flags.
  assumes the parent decodes index and strobes; clock enable gates all state.
*/
`timescale 1ns/100ps
module uir_ep_slot
  import uir_pkg::*;
#(
  parameter bit IS_EP0 = 1'b0
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rstn,
  input  wire logic       i_ce,
  input  wire logic       i_bus_reset,
  input  wire logic       i_wr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_nak_in_evt,
  input  wire logic       i_nak_out_evt,
  output logic            o_ep_en,
  output logic            o_nak_ien,
  output logic            o_nak_in,
  output logic            o_nak_out
);

  typedef struct packed {
    logic ep_en;
    logic nak_ien;
    logic nak_in;
    logic nak_out;
  } uir_slot_type;

  uir_slot_type st_r;
  uir_slot_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (i_wr) begin
      st_nxt.ep_en   = i_wdata[UIR_BIT_EP_EN];
      st_nxt.nak_ien = i_wdata[UIR_BIT_NAK_IEN];
      // software clears a flag by writing zero; a new event still wins
      if (!i_wdata[UIR_BIT_NAK_IN])
        st_nxt.nak_in = 1'b0;
      if (!i_wdata[UIR_BIT_NAK_OUT])
        st_nxt.nak_out = 1'b0;
    end
    if (i_nak_in_evt)
      st_nxt.nak_in = 1'b1;
    if (i_nak_out_evt)
      st_nxt.nak_out = 1'b1;
    if (i_bus_reset) begin
      st_nxt         = '0;
      st_nxt.ep_en   = IS_EP0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r       <= '0;
      st_r.ep_en <= IS_EP0;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  assign o_ep_en   = st_r.ep_en;
  assign o_nak_ien = st_r.nak_ien;
  assign o_nak_in  = st_r.nak_in;
  assign o_nak_out = st_r.nak_out;

endmodule // uir_ep_slot

// ===== src/uir_regs.sv
/*
  usb interrupt enable, device address, endpoint index and indexed endpoint
  control registers, with the usb interrupt request built from them. each of
  the seven endpoints keeps its own enable, nak interrupt enable and nak
  flags in a slot module; the index register picks which slot the cpu sees.
  assumes a same-clock sfr bus (one-cycle write strobe, combinational read)
  and event pulses from the usb engine on the same clock, so no input passes
  a synchroniser. the global event flags live outside this slice and arrive
  as levels; the bus reset pulse comes from the usb engine on this clock too.
  a low clock enable freezes every register here and in the slots.
*/
// Behaviour
// - wake-up enable gates wake-up interrupt request
// - end-of-reset enable resets set, gates interrupt
// - frame-start enable gates start-of-frame interrupt
// - suspend enable gates suspend interrupt request
// - reserved bits read back as zero
// - interrupt enable register resets to 0x10
// - address bit 7 enables the usb function
// - address field zero after reset, bus reset
// - endpoint select routes indexed register access
// - endpoint index register resets to zero
// - endpoint control bit 7 enables endpoint
// - endpoint zero enabled after every reset
// - nak interrupt enable gates both nak flags
// - event flags request interrupt only when enabled
// - nak-out flag set when out is naked
`timescale 1ns/100ps
module uir_regs
  import uir_pkg::*;
#(
  parameter int NUM_EP = UIR_NUM_EP
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_rstn,
  input  wire logic              i_ce,
  input  wire logic              i_bus_reset,
  input  wire logic [7:0]        i_sfr_addr,
  input  wire logic              i_sfr_wr,
  input  wire logic [7:0]        i_sfr_wdata,
  input  wire logic              i_sfr_rd,
  output logic      [7:0]        o_sfr_rdata,
  output logic                   o_sfr_hit,
  input  wire logic              i_wake_cpu_flag,
  input  wire logic              i_end_of_reset_flag,
  input  wire logic              i_frame_start_flag,
  input  wire logic              i_suspend_flag,
  input  wire logic [NUM_EP-1:0] i_nak_in_evt,
  input  wire logic [NUM_EP-1:0] i_nak_out_evt,
  output logic                   o_function_enable,
  output logic      [6:0]        o_device_address_field,
  output logic      [NUM_EP-1:0] o_endpoint_enable,
  output logic      [NUM_EP-1:0] o_nak_in_sent_flag,
  output logic      [NUM_EP-1:0] o_nak_out_sent_flag,
  output logic                   o_usb_irq
);

  //****************************************************************
  // register state
  //****************************************************************
  typedef struct packed {
    logic [7:0] irq_en;
    logic [7:0] dev_addr;
    logic [7:0] ep_index;
  } uir_regs_type;

  uir_regs_type st_r;
  uir_regs_type st_nxt;

  logic [NUM_EP-1:0] ep_wr;
  logic [NUM_EP-1:0] ep_en;
  logic [NUM_EP-1:0] nak_ien;
  logic [NUM_EP-1:0] nak_in;
  logic [NUM_EP-1:0] nak_out;
  logic [3:0]        sel;

  assign sel = st_r.ep_index[3:0];

  //****************************************************************
  // address decode
  //****************************************************************
  // a selector of seven or more points at no endpoint copy; the slot write
  // strobes and the read mux must agree on that, so both ask this function
  function automatic logic uir_sel_valid(input logic [3:0] s);
    uir_sel_valid = (s < 4'(NUM_EP));
  endfunction

  logic wr_irq_en;
  logic wr_dev_addr;
  logic wr_ep_index;
  logic wr_ep_cfg;

  assign wr_irq_en   = i_sfr_wr && (i_sfr_addr == UIR_OFS_IRQ_EN);
  assign wr_dev_addr = i_sfr_wr && (i_sfr_addr == UIR_OFS_DEV_ADDR);
  assign wr_ep_index = i_sfr_wr && (i_sfr_addr == UIR_OFS_EP_INDEX);
  // a write to a missing endpoint reaches no slot and is simply lost
  assign wr_ep_cfg   = i_sfr_wr && (i_sfr_addr == UIR_OFS_EP_CONFIG) && uir_sel_valid(sel);

  //****************************************************************
  // register write path
  //****************************************************************
  always_comb begin
    st_nxt = st_r;
    if (wr_irq_en)
      st_nxt.irq_en = i_sfr_wdata & UIR_MASK_IRQ_EN;
    if (wr_dev_addr)
      st_nxt.dev_addr = i_sfr_wdata;
    if (wr_ep_index)
      st_nxt.ep_index = i_sfr_wdata & UIR_MASK_EP_INDEX;
    // bus reset only returns the address field to zero here; the interrupt and function enables stay as set
    if (i_bus_reset)
      st_nxt.dev_addr[6:0] = 7'h00;
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r.irq_en   <= UIR_RST_IRQ_EN;
      // both address fields come up zero, so no package constant is needed
      st_r.dev_addr <= 8'h00;
      st_r.ep_index <= UIR_RST_EP_INDEX;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  //****************************************************************
  // per-endpoint control copies
  //****************************************************************
  genvar g;
  generate
    for (g = 0; g < NUM_EP; g++) begin : g_ep
      // each slot sees only its own strobe, so the other copies hold
      assign ep_wr[g] = wr_ep_cfg && (sel == 4'(g));
      uir_ep_slot #(
        .IS_EP0 (g == 0)
      ) u_slot (
        .i_clk_sys     (i_clk_sys),
        .i_rstn        (i_rstn),
        .i_ce          (i_ce),
        .i_bus_reset   (i_bus_reset),
        .i_wr          (ep_wr[g]),
        .i_wdata       (i_sfr_wdata),
        .i_nak_in_evt  (i_nak_in_evt[g]),
        .i_nak_out_evt (i_nak_out_evt[g]),
        .o_ep_en       (ep_en[g]),
        .o_nak_ien     (nak_ien[g]),
        .o_nak_in      (nak_in[g]),
        .o_nak_out     (nak_out[g])
      );
    end
  endgenerate

  //****************************************************************
  // selected endpoint view
  //****************************************************************
  // bits 3 to 0 of the endpoint control byte belong to logic outside this
  // slice, so they read as zero here
  logic [7:0] ep_cfg_rd;

  always_comb begin
    ep_cfg_rd = 8'h00;
    if (uir_sel_valid(sel)) begin
      ep_cfg_rd[UIR_BIT_EP_EN]   = ep_en[sel[2:0]];
      ep_cfg_rd[UIR_BIT_NAK_IEN] = nak_ien[sel[2:0]];
      ep_cfg_rd[UIR_BIT_NAK_OUT] = nak_out[sel[2:0]];
      ep_cfg_rd[UIR_BIT_NAK_IN]  = nak_in[sel[2:0]];
    end
  end

  //****************************************************************
  // read mux
  //****************************************************************
  // read data is combinational so the cpu takes it in the access cycle
  always_comb begin
    o_sfr_rdata = 8'h00;
    o_sfr_hit   = 1'b1;
    case (i_sfr_addr)
      UIR_OFS_IRQ_EN:    o_sfr_rdata = st_r.irq_en & UIR_MASK_IRQ_EN;
      UIR_OFS_DEV_ADDR:  o_sfr_rdata = st_r.dev_addr;
      UIR_OFS_EP_INDEX:  o_sfr_rdata = st_r.ep_index & UIR_MASK_EP_INDEX;
      UIR_OFS_EP_CONFIG: o_sfr_rdata = ep_cfg_rd;
      default:          o_sfr_hit = 1'b0;
    endcase
    if (!i_sfr_rd)
      o_sfr_rdata = 8'h00;
  end

  //****************************************************************
  // interrupt request
  //****************************************************************
  // the global flags are kept in a status register outside this slice and
  // arrive as levels, so the request stays up until software clears a flag
  // or its enable; it is not a pulse and needs no edge detector
  logic              irq_wake;
  logic              irq_eor;
  logic              irq_sof;
  logic              irq_susp;
  logic              irq_nak;
  logic [NUM_EP-1:0] nak_pend;

  assign irq_wake = i_wake_cpu_flag     && st_r.irq_en[UIR_BIT_WAKE_EN];
  assign irq_eor  = i_end_of_reset_flag && st_r.irq_en[UIR_BIT_EOR_EN];
  assign irq_sof  = i_frame_start_flag  && st_r.irq_en[UIR_BIT_SOF_EN];
  assign irq_susp = i_suspend_flag      && st_r.irq_en[UIR_BIT_SUSP_EN];

  // one enable per endpoint covers both directions of nak report
  assign nak_pend = nak_ien & (nak_in | nak_out);
  assign irq_nak  = |nak_pend;

  always_comb begin
    o_usb_irq = irq_wake || irq_eor || irq_sof || irq_susp || irq_nak;
  end

  //****************************************************************
  // outputs
  //****************************************************************
  assign o_function_enable      = st_r.dev_addr[UIR_BIT_FUNC_EN];
  assign o_device_address_field = st_r.dev_addr[6:0];
  assign o_endpoint_enable      = ep_en;
  assign o_nak_in_sent_flag     = nak_in;
  assign o_nak_out_sent_flag    = nak_out;

endmodule // uir_regs

// ===== sim/uir_regs_checker.sv
/* checker for the usb register slice, sees top ports only.
   assumes one clock and an async active-low reset. */
`timescale 1ns/100ps
module uir_regs_checker
  import uir_pkg::*;
#(parameter int NUM_EP = UIR_NUM_EP) (
  input wire logic              i_clk_sys,
  input wire logic              i_rstn,
  input wire logic              i_ce,
  input wire logic              i_bus_reset,
  input wire logic [7:0]        i_sfr_addr,
  input wire logic              i_sfr_wr,
  input wire logic [7:0]        i_sfr_wdata,
  input wire logic              i_sfr_rd,
  input wire logic [7:0]        o_sfr_rdata,
  input wire logic              i_wake_cpu_flag,
  input wire logic              i_end_of_reset_flag,
  input wire logic              i_frame_start_flag,
  input wire logic              i_suspend_flag,
  input wire logic [NUM_EP-1:0] i_nak_out_evt,
  input wire logic              o_function_enable,
  input wire logic [6:0]        o_device_address_field,
  input wire logic [NUM_EP-1:0] o_endpoint_enable,
  input wire logic [NUM_EP-1:0] o_nak_in_sent_flag,
  input wire logic [NUM_EP-1:0] o_nak_out_sent_flag,
  input wire logic              o_usb_irq
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  // ****
  // properties
  // ****
  addr_write_a: assert property (i_sfr_wr && i_ce && !i_bus_reset && i_sfr_addr == UIR_OFS_DEV_ADDR |=>
    {o_function_enable, o_device_address_field} == $past(i_sfr_wdata)) else $error("address write lost");
  bus_rst_a: assert property (i_bus_reset && i_ce && !i_sfr_wr |=>
    o_device_address_field == 7'h00 && o_endpoint_enable[0]) else $error("bus reset not applied");
  resv_irq_a: assert property (i_sfr_rd && i_sfr_addr == UIR_OFS_IRQ_EN |-> (o_sfr_rdata & 8'hC6) == 8'h00)
    else $error("irq enable reserved bit set");
  resv_index_a: assert property (i_sfr_rd && i_sfr_addr == UIR_OFS_EP_INDEX |-> o_sfr_rdata[7:4] == 4'h0)
    else $error("index reserved bit set");
  irq_gate_a: assert property (i_sfr_rd && i_sfr_addr == UIR_OFS_IRQ_EN && !(|o_nak_in_sent_flag)
    && !(|o_nak_out_sent_flag) |-> o_usb_irq == |(o_sfr_rdata & {2'h0, i_wake_cpu_flag, i_end_of_reset_flag,
    i_frame_start_flag, 2'h0, i_suspend_flag})) else $error("irq gating wrong");
  nak_set_a: assert property (i_ce && !i_bus_reset && |i_nak_out_evt |=>
    (o_nak_out_sent_flag & $past(i_nak_out_evt)) == $past(i_nak_out_evt)) else $error("nak out flag missed");
  ce_freeze_a: assert property (!i_ce |=> $stable({o_function_enable, o_device_address_field, o_endpoint_enable,
    o_nak_out_sent_flag})) else $error("state moved with clock enable low");
  reset_val_a: assert property ($rose(i_rstn) |-> o_endpoint_enable == 7'h01 &&
    o_device_address_field == 7'h00) else $error("reset values wrong");
  cover property (|o_nak_out_sent_flag && o_usb_irq);
  cover property (i_bus_reset && i_ce);
  cover property (i_sfr_wr && i_sfr_addr == UIR_OFS_EP_CONFIG);
endmodule // uir_regs_checker

// ===== sim/uir_host_model.sv
/* usb host stand-in: global event flags and per-endpoint nak pulses.
   assumes the bench calls its tasks from one process. */
`timescale 1ns/100ps
module uir_host_model (
  input  wire logic       i_clk_sys,
  output logic      [3:0] o_flags,
  output logic      [6:0] o_nak_in,
  output logic      [6:0] o_nak_out
);
  initial o_flags = 4'h0;
  initial o_nak_in = 7'h00;
  initial o_nak_out = 7'h00;
  // ****
  // host actions
  // ****
  task automatic set_flags(input logic [3:0] f);
    @(negedge i_clk_sys);
    o_flags = f;
  endtask
  // a nak handshake shows as a one-cycle pulse
  task automatic nak(input logic dir_out, input int ep);
    @(negedge i_clk_sys);
    if (dir_out) o_nak_out[ep] = 1'b1;
    else o_nak_in[ep] = 1'b1;
    @(negedge i_clk_sys);
    o_nak_out = 7'h00;
    o_nak_in = 7'h00;
  endtask
endmodule // uir_host_model

// ===== sim/usb_device_irq_addr_endpoint_regs_tb.sv
/* bench for the usb register slice with a host stand-in.
   assumes inputs change on the falling edge. */
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; $display("BAD t=%0t %h %h", $time, g, e); end end
module usb_device_irq_addr_endpoint_regs_tb;
  import uir_pkg::*;
  logic       i_clk_sys;
  logic       i_rstn = 1'b0;
  logic       i_ce = 1'b1;
  logic       i_bus_reset = 1'b0;
  logic [7:0] i_sfr_addr = 8'h00;
  logic       i_sfr_wr = 1'b0;
  logic [7:0] i_sfr_wdata = 8'h00;
  logic       i_sfr_rd = 1'b0;
  logic [7:0] o_sfr_rdata;
  logic       o_sfr_hit;
  logic [3:0] flags;
  logic [6:0] nak_in;
  logic [6:0] nak_out;
  logic       o_function_enable;
  logic [6:0] o_device_address_field;
  logic [6:0] o_endpoint_enable;
  logic [6:0] o_nak_in_sent_flag;
  logic [6:0] o_nak_out_sent_flag;
  logic       o_usb_irq;
  int         mismatches = 0;
  int         n_tests = 0;
  logic [7:0] en [4] = '{8'h01, 8'h08, 8'h10, 8'h20};
  // rows keep interrupt enable and index reserved bits clear and select only endpoints 0 to 6
  logic [7:0] rows [8][3] = '{'{8'hBE, 8'h39, 8'h39}, '{8'hBE, 8'h00, 8'h00}, '{8'hC6, 8'hFF, 8'hFF},
    '{8'hC6, 8'h05, 8'h05}, '{8'hC7, 8'h06, 8'h06}, '{8'hC7, 8'h03, 8'h03},
    '{8'hD4, 8'hFF, 8'hC0}, '{8'hD4, 8'h00, 8'h00}};
  uir_regs u_uir_regs (
    .i_clk_sys              (i_clk_sys),
    .i_rstn                 (i_rstn),
    .i_ce                   (i_ce),
    .i_bus_reset            (i_bus_reset),
    .i_sfr_addr             (i_sfr_addr),
    .i_sfr_wr               (i_sfr_wr),
    .i_sfr_wdata            (i_sfr_wdata),
    .i_sfr_rd               (i_sfr_rd),
    .o_sfr_rdata            (o_sfr_rdata),
    .o_sfr_hit              (o_sfr_hit),
    .i_wake_cpu_flag        (flags[3]),
    .i_end_of_reset_flag    (flags[2]),
    .i_frame_start_flag     (flags[1]),
    .i_suspend_flag         (flags[0]),
    .i_nak_in_evt           (nak_in),
    .i_nak_out_evt          (nak_out),
    .o_function_enable      (o_function_enable),
    .o_device_address_field (o_device_address_field),
    .o_endpoint_enable      (o_endpoint_enable),
    .o_nak_in_sent_flag     (o_nak_in_sent_flag),
    .o_nak_out_sent_flag    (o_nak_out_sent_flag),
    .o_usb_irq              (o_usb_irq)
  );
  uir_host_model u_uir_host_model (.i_clk_sys, .o_flags(flags), .o_nak_in(nak_in), .o_nak_out(nak_out));
  initial begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  // ****
  // bus tasks
  // ****
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk_sys);
    i_sfr_addr = a;
    i_sfr_wdata = d;
    i_sfr_wr = 1'b1;
    @(negedge i_clk_sys);
    i_sfr_wr = 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(negedge i_clk_sys);
    i_sfr_addr = a;
    i_sfr_rd = 1'b1;
    #2;
    `CHK(o_sfr_rdata, e)
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // the whole run is about 90 cycles, so this limit only cuts a hang
  initial begin
    #20000;
    mismatches++;
    complete_run();
  end
  initial begin
    repeat (3) @(negedge i_clk_sys);
    i_rstn = 1'b1;
    foreach (rows[i]) begin
      wr(rows[i][0], rows[i][1]);
      rdchk(rows[i][0], rows[i][2]);
    end
    $display("table done");
    wr(8'hC7, 8'h01);
    wr(8'hD4, 8'hC0);
    wr(8'hC7, 8'h02);
    wr(8'hD4, 8'h00);
    wr(8'hC7, 8'h01);
    rdchk(8'hD4, 8'hC0);
    `CHK(o_sfr_hit, 1'b1)
    `CHK(o_endpoint_enable, 7'h03)
    $display("endpoint copies done");
    for (int k = 0; k < 4; k++) begin
      u_uir_host_model.set_flags(4'h1 << k);
      wr(UIR_OFS_IRQ_EN, en[k]);
      rdchk(UIR_OFS_IRQ_EN, en[k]);
      `CHK(o_usb_irq, 1'b1)
      wr(UIR_OFS_IRQ_EN, 8'h00);
      #2;
      `CHK(o_usb_irq, 1'b0)
    end
    u_uir_host_model.set_flags(4'h0);
    $display("irq gating done");
    wr(8'hC7, 8'h03);
    wr(8'hD4, 8'h40);
    u_uir_host_model.nak(1'b1, 3);
    #2;
    `CHK(o_nak_out_sent_flag, 7'h08)
    `CHK(o_usb_irq, 1'b1)
    wr(8'hD4, 8'h40);
    #2;
    `CHK(o_nak_out_sent_flag, 7'h00)
    wr(8'hD4, 8'h00);
    u_uir_host_model.nak(1'b0, 3);
    #2;
    `CHK(o_usb_irq, 1'b0)
    `CHK(o_nak_in_sent_flag, 7'h08)
    $display("nak done");
    wr(8'hC6, 8'h85);
    `CHK(o_function_enable, 1'b1)
    i_ce = 1'b0;
    wr(8'hC6, 8'h7F);
    i_ce = 1'b1;
    `CHK(o_device_address_field, 7'h05)
    @(negedge i_clk_sys);
    i_bus_reset = 1'b1;
    @(negedge i_clk_sys);
    i_bus_reset = 1'b0;
    #2;
    `CHK(o_device_address_field, 7'h00)
    `CHK(o_endpoint_enable, 7'h01)
    $display("bus reset done");
    @(negedge i_clk_sys);
    i_rstn = 1'b0;
    @(negedge i_clk_sys);
    i_rstn = 1'b1;
    rdchk(UIR_OFS_IRQ_EN, 8'h10);
    rdchk(UIR_OFS_EP_INDEX, 8'h00);
    rdchk(UIR_OFS_DEV_ADDR, 8'h00);
    rdchk(UIR_OFS_EP_CONFIG, 8'h80);
    rdchk(8'h00, 8'h00);
    `CHK(o_sfr_hit, 1'b0)
    $display("reset done");
    complete_run();
  end
endmodule // usb_device_irq_addr_endpoint_regs_tb
bind uir_regs uir_regs_checker #(.NUM_EP(NUM_EP)) u_uir_regs_checker (.*);
